// ===== rtl/ccr_pkg.sv
// Constants, register map and field layout of the capability report block
package ccr_pkg;

   // ****************************************************************
   // Identification leaves and word selects
   // ****************************************************************
   localparam logic [31:0] CCR_LEAF_POWER = 32'h8000_0007;
   localparam logic [31:0] CCR_LEAF_ADDR = 32'h8000_0008;
   localparam logic [31:0] CCR_LEAF_RSVD = 32'h8000_0009;
   localparam logic [31:0] CCR_LEAF_VIRT = 32'h8000_000a;
   localparam logic [1:0] CCR_WORD_A = 2'h0;
   localparam logic [1:0] CCR_WORD_B = 2'h1;
   localparam logic [1:0] CCR_WORD_C = 2'h2;
   localparam logic [1:0] CCR_WORD_D = 2'h3;

   // ****************************************************************
   // Power feature flag positions (word D of the power leaf)
   // ****************************************************************
   localparam int CCR_PF_TEMP_SENSOR = 0;
   localparam int CCR_PF_FREQ_CODE = 1;
   localparam int CCR_PF_VOLT_CODE = 2;
   localparam int CCR_PF_THERMAL_TRIP = 3;
   localparam int CCR_PF_HW_THROTTLE = 4;
   localparam int CCR_PF_SW_THROTTLE = 5;

   // ****************************************************************
   // Address width leaf values and the virtualization ASID count
   // ****************************************************************
   localparam logic [7:0] CCR_LIN_WIDTH_LONG = 8'h30;
   localparam logic [7:0] CCR_LIN_WIDTH_LEGACY = 8'h20;
   localparam logic [7:0] CCR_PHYS_WIDTH = 8'h28;
   localparam logic [31:0] CCR_ASID_COUNT = 32'h0000_0040;

   // ****************************************************************
   // Configuration space map
   // ****************************************************************
   localparam logic [2:0] CCR_FUNC_LINK = 3'h0;
   localparam logic [2:0] CCR_FUNC_NB = 3'h3;
   localparam logic [7:0] CCR_OFF_LINK_FAIL = 8'h84;
   localparam logic [7:0] CCR_OFF_LINK_FREQ = 8'h88;
   localparam logic [7:0] CCR_OFF_LINK_CONN = 8'h98;
   localparam logic [7:0] CCR_OFF_NB_CAP = 8'he8;
   localparam int CCR_LF_FAIL_BIT = 4;
   localparam int CCR_LC_CONN_BIT = 0;
   localparam int CCR_LC_PEND_BIT = 4;
   localparam int CCR_FREQ_SEL_LSB = 8;
   localparam int CCR_FREQ_CAP_LSB = 16;
   localparam int CCR_NB_DUAL_BIT = 0;
   localparam int CCR_NB_MULTI_BIT = 1;
   localparam logic [3:0] CCR_FREQ_SEL_RESET = 4'h0;

   // ****************************************************************
   // Multiprocessing classes and link detection timing
   // ****************************************************************
   localparam logic [1:0] CCR_MP_UNI = 2'h0;
   localparam logic [1:0] CCR_MP_DUAL = 2'h1;
   localparam logic [1:0] CCR_MP_MULTI = 2'h2;
   localparam int CCR_CLK_MHZ = 250;
   localparam int CCR_DETECT_NS = 1000;
   localparam int CCR_DETECT_CYCLES = (CCR_DETECT_NS * CCR_CLK_MHZ + 999) / 1000;

   typedef logic [31:0] ccr_word_t;

endpackage

// ===== rtl/ccr_sync2.sv
// Two flip-flop synchroniser for one pin level
`timescale 1ns/1ps
module ccr_sync2 #(
   parameter logic RESET_VAL = 1'b0
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic pin_in,
   output logic level_out
);
   typedef struct packed {
      logic meta;
      logic stable;
   } ccr_sync_t;

   ccr_sync_t s_q;
   ccr_sync_t s_d;

   // First stage feeds only the second stage
   always_comb begin
      s_d.meta = pin_in;
      s_d.stable = s_q.meta;
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '{meta: RESET_VAL, stable: RESET_VAL};
      end else begin
         s_q <= s_d;
      end
   end

   assign level_out = s_q.stable;
endmodule

// ===== rtl/ccr_link_detect.sv
// Link detection timer: holds pending, then latches connection state
`timescale 1ns/1ps
module ccr_link_detect
   import ccr_pkg::*;
#(
   parameter int DETECT_CYCLES = CCR_DETECT_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic restart,
   input wire logic link_up,
   output logic link_detect_pending,
   output logic link_connected
);
   localparam int CW = $clog2(DETECT_CYCLES + 1);

   // A zero count would leave the pending flag stuck
   if (DETECT_CYCLES < 1) begin : g_bad_detect
      $error("DETECT_CYCLES must be at least one");
   end

   typedef struct packed {
      logic pend;
      logic conn;
      logic [CW-1:0] cnt;
   } ccr_det_t;

   ccr_det_t s_q;
   ccr_det_t s_d;

   // Restart wins over completion so a reset mid-count re-runs detection
   always_comb begin
      s_d = s_q;
      if (restart) begin
         s_d.pend = 1'b1;
         s_d.conn = 1'b0;
         s_d.cnt = '0;
      end else if (s_q.pend) begin
         if (s_q.cnt == CW'(DETECT_CYCLES - 1)) begin
            s_d.pend = 1'b0;
            s_d.conn = link_up;
         end else begin
            s_d.cnt = s_q.cnt + CW'(1);
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '{pend: 1'b1, conn: 1'b0, cnt: '0};
      end else begin
         s_q <= s_d;
      end
   end

   assign link_detect_pending = s_q.pend;
   assign link_connected = s_q.conn;
endmodule

// ===== rtl/ccr_capability_regs.sv
// Capability report block: identification leaves and link config space
`timescale 1ns/1ps

module ccr_capability_regs
   import ccr_pkg::*;
#(
   parameter logic LONG_MODE = 1'b1,
   parameter int CORE_COUNT = 1,
   parameter logic SW_THROTTLE = 1'b1,
   parameter logic HW_THROTTLE = 1'b1,
   parameter logic VOLT_CODE = 1'b1,
   parameter logic FREQ_CODE = 1'b1,
   parameter logic VIRT_EN = 1'b1,
   // Arbitrary revision value, not tied to any real part
   parameter logic [7:0] VIRT_REVISION = 8'h5a,
   parameter logic [1:0] MP_CLASS = CCR_MP_MULTI,
   parameter logic [15:0] LINK_FREQ_CAP = 16'h0075,
   parameter int DETECT_CYCLES = CCR_DETECT_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic warm_rst_n,
   input wire logic link_present,
   input wire logic sync_flood,
   input wire logic leaf_req,
   input wire logic [31:0] leaf_fn,
   input wire logic [1:0] leaf_word,
   output logic leaf_ack,
   output logic [31:0] leaf_data,
   input wire logic cfg_req,
   input wire logic cfg_we,
   input wire logic [2:0] cfg_func,
   input wire logic [7:0] cfg_off,
   input wire logic [31:0] cfg_wdata,
   output logic cfg_ack,
   output logic [31:0] cfg_rdata,
   output logic [3:0] link_freq_sel
);

   // ****************************************************************
   // Elaboration checks
   // ****************************************************************
   // Values that the logic below cannot serve stop elaboration
   if (CORE_COUNT < 1 || CORE_COUNT > 256) begin : g_bad_cores
      $error("CORE_COUNT must lie in 1..256");
   end
   if (MP_CLASS > CCR_MP_MULTI) begin : g_bad_mp
      $error("MP_CLASS must be uni, dual or multi");
   end
   if (DETECT_CYCLES < 1) begin : g_bad_detect
      $error("DETECT_CYCLES must be at least one");
   end
   // Both resets load this code, so it must be a capable one
   if (LINK_FREQ_CAP[CCR_FREQ_SEL_RESET] == 1'b0) begin : g_bad_cap
      $error("LINK_FREQ_CAP must include the reset frequency code");
   end
   // The selection field sits below the capability field
   if (CCR_FREQ_SEL_LSB + 4 > CCR_FREQ_CAP_LSB) begin : g_bad_map
      $error("frequency select field overlaps the capability field");
   end
   // Pending and connected flags need their own bits
   if (CCR_LC_PEND_BIT == CCR_LC_CONN_BIT) begin : g_bad_conn
      $error("pending and connected flags share a bit");
   end

   // ****************************************************************
   // Constant leaf words and the northbridge capability word
   // ****************************************************************
   ccr_word_t power_feature_flags;
   ccr_word_t address_width_info;
   ccr_word_t core_count_info;
   ccr_word_t virt_revision_info;
   ccr_word_t virt_asid_count;
   ccr_word_t northbridge_capability;

   // Power flags: fixed ones plus product options, upper bits zero
   always_comb begin
      power_feature_flags = '0;
      power_feature_flags[CCR_PF_TEMP_SENSOR] = 1'b1;
      power_feature_flags[CCR_PF_THERMAL_TRIP] = 1'b1;
      power_feature_flags[CCR_PF_SW_THROTTLE] = SW_THROTTLE;
      power_feature_flags[CCR_PF_HW_THROTTLE] = HW_THROTTLE;
      power_feature_flags[CCR_PF_VOLT_CODE] = VOLT_CODE;
      power_feature_flags[CCR_PF_FREQ_CODE] = FREQ_CODE;
   end

   // Address widths: linear width follows the long mode option
   always_comb begin
      address_width_info = '0;
      address_width_info[15:8] = LONG_MODE ? CCR_LIN_WIDTH_LONG
                                           : CCR_LIN_WIDTH_LEGACY;
      address_width_info[7:0] = CCR_PHYS_WIDTH;
   end

   // Core count minus one; a single core reads zero
   always_comb begin
      core_count_info = '0;
      core_count_info[7:0] = 8'(CORE_COUNT - 1);
   end

   // Virtualization words; whole leaf is zero when the feature is absent
   always_comb begin
      virt_revision_info = '0;
      virt_revision_info[7:0] = VIRT_REVISION;
      virt_asid_count = CCR_ASID_COUNT;
   end

   // Multiprocessing class as a two-bit code
   always_comb begin
      northbridge_capability = '0;
      northbridge_capability[CCR_NB_DUAL_BIT] = (MP_CLASS != CCR_MP_UNI);
      northbridge_capability[CCR_NB_MULTI_BIT] = (MP_CLASS == CCR_MP_MULTI);
   end

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic warm_rst_n_s;
   logic link_present_s;
   logic sync_flood_s;

   ccr_sync2 #(.RESET_VAL(1'b1)) u_sync_warm (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .pin_in(warm_rst_n),
      .level_out(warm_rst_n_s)
   );

   ccr_sync2 #(.RESET_VAL(1'b0)) u_sync_link (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .pin_in(link_present),
      .level_out(link_present_s)
   );

   ccr_sync2 #(.RESET_VAL(1'b0)) u_sync_flood (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .pin_in(sync_flood),
      .level_out(sync_flood_s)
   );

   // ****************************************************************
   // Block state
   // ****************************************************************
   typedef struct packed {
      logic link_fail;
      logic [3:0] freq_sel;
      logic leaf_ack;
      logic [31:0] leaf_data;
      logic cfg_ack;
      logic [31:0] cfg_rdata;
   } ccr_state_t;

   ccr_state_t s_q;
   ccr_state_t s_d;

   logic in_warm;
   logic detect_pending;
   logic detect_connected;

   // ****************************************************************
   // Link detection
   // ****************************************************************
   // Warm reset as seen after the synchroniser; the pin is held low
   assign in_warm = !warm_rst_n_s;

   // Detection stays at its start while warm reset is held, so the
   // pending flag also covers the time after release
   ccr_link_detect #(.DETECT_CYCLES(DETECT_CYCLES)) u_detect (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .restart(in_warm),
      .link_up(link_present_s),
      .link_detect_pending(detect_pending),
      .link_connected(detect_connected)
   );

   // ****************************************************************
   // Register views and decode
   // ****************************************************************
   ccr_word_t link_fail_control;
   ccr_word_t link_frequency_select;
   ccr_word_t link_connect_state;
   ccr_word_t leaf_word_val;
   ccr_word_t cfg_word_val;
   logic hit_fail;
   logic hit_freq;
   logic hit_conn;
   logic hit_nbcap;
   logic freq_ok;
   logic [3:0] wr_freq;
   logic wr_freq_take;
   logic wr_fail_clr;

   // Readable images of the link registers
   always_comb begin
      link_fail_control = '0;
      link_fail_control[CCR_LF_FAIL_BIT] = s_q.link_fail;
      link_frequency_select = '0;
      link_frequency_select[CCR_FREQ_CAP_LSB +: 16] = LINK_FREQ_CAP;
      link_frequency_select[CCR_FREQ_SEL_LSB +: 4] = s_q.freq_sel;
      link_connect_state = '0;
      link_connect_state[CCR_LC_PEND_BIT] = detect_pending;
      link_connect_state[CCR_LC_CONN_BIT] = detect_connected;
   end

   // ****************************************************************
   // Identification leaf lookup
   // ****************************************************************
   // Leaf lookup; anything not listed, reserved words included, is zero
   always_comb begin
      leaf_word_val = '0;
      if (leaf_fn == CCR_LEAF_POWER && leaf_word == CCR_WORD_D) begin
         leaf_word_val = power_feature_flags;
      end else if (leaf_fn == CCR_LEAF_ADDR && leaf_word == CCR_WORD_A) begin
         leaf_word_val = address_width_info;
      end else if (leaf_fn == CCR_LEAF_ADDR && leaf_word == CCR_WORD_C) begin
         leaf_word_val = core_count_info;
      end else if (VIRT_EN && leaf_fn == CCR_LEAF_VIRT && leaf_word == CCR_WORD_A) begin
         leaf_word_val = virt_revision_info;
      end else if (VIRT_EN && leaf_fn == CCR_LEAF_VIRT && leaf_word == CCR_WORD_B) begin
         leaf_word_val = virt_asid_count;
      end
   end

   // ****************************************************************
   // Config space decode
   // ****************************************************************
   // Address decode; unmapped offsets hit nothing and drop writes
   always_comb begin
      hit_fail = 1'b0;
      hit_freq = 1'b0;
      hit_conn = 1'b0;
      hit_nbcap = 1'b0;
      if (cfg_func == CCR_FUNC_LINK && cfg_off == CCR_OFF_LINK_FAIL) begin
         hit_fail = 1'b1;
      end else if (cfg_func == CCR_FUNC_LINK && cfg_off == CCR_OFF_LINK_FREQ) begin
         hit_freq = 1'b1;
      end else if (cfg_func == CCR_FUNC_LINK && cfg_off == CCR_OFF_LINK_CONN) begin
         hit_conn = 1'b1;
      end else if (cfg_func == CCR_FUNC_NB && cfg_off == CCR_OFF_NB_CAP) begin
         hit_nbcap = 1'b1;
      end
   end

   // Read mux; the hits are exclusive and no hit reads zero
   always_comb begin
      cfg_word_val = '0;
      if (hit_fail) begin
         cfg_word_val = link_fail_control;
      end else if (hit_freq) begin
         cfg_word_val = link_frequency_select;
      end else if (hit_conn) begin
         cfg_word_val = link_connect_state;
      end else if (hit_nbcap) begin
         cfg_word_val = northbridge_capability;
      end
   end

   // ****************************************************************
   // Write strobes
   // ****************************************************************
   // A frequency code is only taken when its capability bit is set
   assign wr_freq = cfg_wdata[CCR_FREQ_SEL_LSB +: 4];
   assign freq_ok = LINK_FREQ_CAP[wr_freq];

   // A write refused during warm reset must change nothing either
   assign wr_freq_take = cfg_req && cfg_we && hit_freq && freq_ok && !in_warm;
   assign wr_fail_clr = cfg_req && cfg_we && hit_fail && !in_warm &&
                        cfg_wdata[CCR_LF_FAIL_BIT];

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      s_d = s_q;
      s_d.leaf_ack = 1'b0;
      s_d.cfg_ack = 1'b0;
      // Warm reset returns the link speed choice to its default
      if (in_warm) begin
         s_d.freq_sel = CCR_FREQ_SEL_RESET;
      end else if (wr_freq_take) begin
         s_d.freq_sel = wr_freq;
      end
      // Write one clears; a flood seen in the same cycle keeps it set
      if (wr_fail_clr) begin
         s_d.link_fail = 1'b0;
      end
      if (sync_flood_s && !in_warm) begin
         s_d.link_fail = 1'b1;
      end
      // Acks last one cycle; data holds until the next accepted request
      // Requests are refused while the warm reset is held
      if (leaf_req && !in_warm) begin
         s_d.leaf_ack = 1'b1;
         s_d.leaf_data = leaf_word_val;
      end
      if (cfg_req && !in_warm) begin
         s_d.cfg_ack = 1'b1;
         s_d.cfg_rdata = cfg_we ? '0 : cfg_word_val;
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   // Cold reset clears everything; warm reset never reaches here, so
   // the failure flag lives through it
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '{link_fail: 1'b0,
                  freq_sel: CCR_FREQ_SEL_RESET, leaf_ack: 1'b0,
                  leaf_data: '0, cfg_ack: 1'b0, cfg_rdata: '0};
      end else begin
         s_q <= s_d;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   // Outputs straight from the state register
   assign leaf_ack = s_q.leaf_ack;
   assign leaf_data = s_q.leaf_data;
   assign cfg_ack = s_q.cfg_ack;
   assign cfg_rdata = s_q.cfg_rdata;
   assign link_freq_sel = s_q.freq_sel;

endmodule

// ===== verification/ccr_capability_props.sv
// Port-level assertions for the capability report block
`timescale 1ns/1ps
module ccr_capability_props
   import ccr_pkg::*;
#(
   parameter int DETECT_CYCLES = 4,
   parameter int CORE_COUNT = 1,
   parameter logic [15:0] LINK_FREQ_CAP = 16'h0075
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic warm_rst_n,
   input wire logic link_present,
   input wire logic sync_flood,
   input wire logic leaf_req,
   input wire logic [31:0] leaf_fn,
   input wire logic [1:0] leaf_word,
   input wire logic leaf_ack,
   input wire logic [31:0] leaf_data,
   input wire logic cfg_req,
   input wire logic cfg_we,
   input wire logic [2:0] cfg_func,
   input wire logic [7:0] cfg_off,
   input wire logic [31:0] cfg_wdata,
   input wire logic cfg_ack,
   input wire logic [31:0] cfg_rdata,
   input wire logic [3:0] link_freq_sel
);
   // ****
   // Helper state
   // ****
   logic [2:0] warm_hist_q;
   logic [7:0] up_cnt_q;
   logic warm_ok;
   logic freq_wr_ok;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // Warm pin history: the synced copy lags, so demand a long clean run
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         warm_hist_q <= 3'h7;
         up_cnt_q <= 8'h00;
      end else begin
         warm_hist_q <= {warm_hist_q[1:0], warm_rst_n};
         up_cnt_q <= (up_cnt_q == 8'hff) ? up_cnt_q : up_cnt_q + 8'h01;
      end
   end
   assign warm_ok = warm_rst_n && (warm_hist_q == 3'h7);
   assign freq_wr_ok = cfg_req && cfg_we && warm_ok && cfg_func == CCR_FUNC_LINK &&
      cfg_off == CCR_OFF_LINK_FREQ && LINK_FREQ_CAP[cfg_wdata[11:8]];
   // ****
   // Sequences and properties
   // ****
   sequence s_leaf(logic [31:0] f, logic [1:0] w);
      leaf_req && warm_ok && leaf_fn == f && leaf_word == w;
   endsequence
   sequence s_cfg_rd(logic [2:0] f, logic [7:0] o);
      cfg_req && !cfg_we && warm_ok && cfg_func == f && cfg_off == o;
   endsequence
   property p_power;
      s_leaf(CCR_LEAF_POWER, CCR_WORD_D) |=> leaf_ack && leaf_data == 32'h0000_003f;
   endproperty
   property p_addr;
      s_leaf(CCR_LEAF_ADDR, CCR_WORD_A) |=> leaf_data == 32'h0000_3028;
   endproperty
   property p_core;
      s_leaf(CCR_LEAF_ADDR, CCR_WORD_C) |=> leaf_data == 32'(CORE_COUNT - 1);
   endproperty
   property p_asid;
      s_leaf(CCR_LEAF_VIRT, CCR_WORD_B) |=> leaf_data == CCR_ASID_COUNT;
   endproperty
   property p_rsvd;
      leaf_req && warm_ok && leaf_fn == CCR_LEAF_RSVD |=> leaf_ack && leaf_data == 32'h0;
   endproperty
   property p_pending;
      s_cfg_rd(CCR_FUNC_LINK, CCR_OFF_LINK_CONN) ##0 up_cnt_q < 8'h02 |=> cfg_rdata[4];
   endproperty
   property p_mp;
      s_cfg_rd(CCR_FUNC_NB, CCR_OFF_NB_CAP) |=> cfg_ack && cfg_rdata == 32'h3;
   endproperty
   property p_freq_set;
      freq_wr_ok |=> link_freq_sel == $past(cfg_wdata[11:8]);
   endproperty
   property p_freq_hold;
      warm_ok && !freq_wr_ok |=> $stable(link_freq_sel);
   endproperty
   a_power: assert property (p_power) else $error("power flag word wrong");
   a_addr: assert property (p_addr) else $error("address width word wrong");
   a_core: assert property (p_core) else $error("core count wrong");
   a_asid: assert property (p_asid) else $error("asid count wrong");
   a_rsvd: assert property (p_rsvd) else $error("reserved leaf not zero");
   a_pending: assert property (p_pending) else $error("pending clear too early");
   a_mp: assert property (p_mp) else $error("multiprocessing bits wrong");
   a_freq_set: assert property (p_freq_set) else $error("capable code not taken");
   a_freq_hold: assert property (p_freq_hold) else $error("code changed unasked");
endmodule

bind ccr_capability_regs ccr_capability_props #(
   .DETECT_CYCLES(DETECT_CYCLES),
   .CORE_COUNT(CORE_COUNT),
   .LINK_FREQ_CAP(LINK_FREQ_CAP)
) i_ccr_capability_props (
   .sys_clk(sys_clk), .rst_n(rst_n), .warm_rst_n(warm_rst_n),
   .link_present(link_present), .sync_flood(sync_flood), .leaf_req(leaf_req),
   .leaf_fn(leaf_fn), .leaf_word(leaf_word), .leaf_ack(leaf_ack), .leaf_data(leaf_data),
   .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_func(cfg_func), .cfg_off(cfg_off),
   .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
   .link_freq_sel(link_freq_sel)
);

// ===== verification/ccr_capability_regs_tb_top.sv
// Self-checking bench for the capability report block
`timescale 1ns/1ps
module ccr_capability_regs_tb_top
   import ccr_pkg::*;
;
   logic sys_clk, rst_n, warm_rst_n, link_present, sync_flood;
   logic leaf_req, leaf_ack, cfg_req, cfg_we, cfg_ack;
   logic [31:0] leaf_fn, leaf_data, cfg_wdata, cfg_rdata, rnd;
   logic [1:0] leaf_word, wrd;
   logic [2:0] cfg_func;
   logic [7:0] cfg_off;
   logic [3:0] link_freq_sel, sel;
   int num_errors = 0;
   int n_checks = 0;
   int seed = 3;
   int cyc = 0;
   localparam logic [15:0] CAP = 16'h0075;
   // Codes that the far end and the platform can both take
   localparam logic [15:0] PEER_CAP = 16'h0035;

   ccr_capability_regs #(.CORE_COUNT(4), .DETECT_CYCLES(4)) i_ccr_capability_regs (
      .sys_clk(sys_clk), .rst_n(rst_n), .warm_rst_n(warm_rst_n),
      .link_present(link_present), .sync_flood(sync_flood), .leaf_req(leaf_req),
      .leaf_fn(leaf_fn), .leaf_word(leaf_word), .leaf_ack(leaf_ack), .leaf_data(leaf_data),
      .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_func(cfg_func), .cfg_off(cfg_off),
      .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
      .link_freq_sel(link_freq_sel)
   );

   // ****
   // Clock and hang guard
   // ****
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   // The whole run needs well under a thousand cycles
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 4000) begin
         num_errors++;
         give_verdict();
      end
   end

   // ****
   // Helpers
   // ****
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Every task starts and ends 1 ns after a rising edge
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic leaf_chk(input logic [31:0] fn, input logic [1:0] w, input logic [31:0] exp);
      leaf_req = 1'b1;
      leaf_fn = fn;
      leaf_word = w;
      tick(1);
      leaf_req = 1'b0;
      check({31'h0, leaf_ack}, 32'h1);
      check(leaf_data, exp);
      tick(1);
   endtask
   task automatic cfg_op(input logic we, input logic [2:0] f, input logic [7:0] o,
                         input logic [31:0] wd, input logic [31:0] exp);
      cfg_req = 1'b1;
      cfg_we = we;
      cfg_func = f;
      cfg_off = o;
      cfg_wdata = wd;
      tick(1);
      cfg_req = 1'b0;
      check({31'h0, cfg_ack}, 32'h1);
      check(cfg_rdata, exp);
      tick(1);
   endtask
   // Expected identification word, for the parameters set above
   function automatic logic [31:0] exp_leaf(input logic [31:0] fn, input logic [1:0] w);
      exp_leaf = 32'h0;
      if (fn == CCR_LEAF_POWER && w == CCR_WORD_D) exp_leaf = 32'h0000_003f;
      if (fn == CCR_LEAF_ADDR && w == CCR_WORD_A) exp_leaf = {16'h0, 8'h30, 8'h28};
      if (fn == CCR_LEAF_ADDR && w == CCR_WORD_C) exp_leaf = 32'h0000_0003;
      if (fn == CCR_LEAF_VIRT && w == CCR_WORD_A) exp_leaf = 32'h0000_005a;
      if (fn == CCR_LEAF_VIRT && w == CCR_WORD_B) exp_leaf = 32'h0000_0040;
   endfunction
   // Highest code set in both capability masks
   function automatic logic [3:0] best_code(input logic [15:0] a, input logic [15:0] b);
      best_code = 4'h0;
      for (int i = 0; i < 16; i++) begin
         if (a[i] && b[i]) best_code = 4'(i);
      end
   endfunction
   task automatic give_verdict;
      $display("checks=%0d errors=%0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // ****
   // Main sequence
   // ****
   initial begin
      {rst_n, warm_rst_n, link_present, sync_flood} = 4'h6;
      {leaf_req, leaf_word, leaf_fn, cfg_req, cfg_we, cfg_func, cfg_off, cfg_wdata} = '0;
      sel = CCR_FREQ_SEL_RESET;
      tick(2);
      rst_n = 1'b1;
      cfg_op(1'b0, CCR_FUNC_LINK, CCR_OFF_LINK_CONN, 32'h0, 32'h10);
      tick(8);
      cfg_op(1'b0, CCR_FUNC_LINK, CCR_OFF_LINK_CONN, 32'h0, 32'h01);
      $display("test link detect done");
      for (int f = 7; f < 11; f++) begin
         for (int w = 0; w < 4; w++) begin
            rnd = 32'h8000_0000 | 32'(f);
            leaf_chk(rnd, 2'(w), exp_leaf(rnd, 2'(w)));
         end
      end
      repeat (20) begin
         rnd = $random(seed);
         wrd = rnd[5:4];
         rnd = 32'h8000_0000 | (rnd & 32'h0000_000f);
         leaf_chk(rnd, wrd, exp_leaf(rnd, wrd));
      end
      $display("test leaves done");
      cfg_op(1'b0, CCR_FUNC_NB, CCR_OFF_NB_CAP, 32'h0, 32'h3);
      cfg_op(1'b1, CCR_FUNC_NB, CCR_OFF_NB_CAP, 32'hffff_ffff, 32'h0);
      cfg_op(1'b0, CCR_FUNC_NB, CCR_OFF_NB_CAP, 32'h0, 32'h3);
      cfg_op(1'b0, 3'h1, CCR_OFF_LINK_FAIL, 32'h0, 32'h0);
      $display("test capability done");
      // Random codes hit both capable and refused settings
      repeat (24) begin
         rnd = $random(seed);
         cfg_op(1'b1, CCR_FUNC_LINK, CCR_OFF_LINK_FREQ, rnd, 32'h0);
         if (CAP[rnd[11:8]]) sel = rnd[11:8];
         check({28'h0, link_freq_sel}, {28'h0, sel});
         cfg_op(1'b0, CCR_FUNC_LINK, CCR_OFF_LINK_FREQ, 32'h0, {CAP, 4'h0, sel, 8'h0});
      end
      // Both ends run the fastest code that each of them can take
      sel = best_code(CAP, PEER_CAP);
      cfg_op(1'b1, CCR_FUNC_LINK, CCR_OFF_LINK_FREQ, {20'h0, sel, 8'h0}, 32'h0);
      check({28'h0, link_freq_sel}, {28'h0, sel});
      $display("test frequency done");
      cfg_op(1'b0, CCR_FUNC_LINK, CCR_OFF_LINK_FAIL, 32'h0, 32'h0);
      sync_flood = 1'b1;
      tick(4);
      sync_flood = 1'b0;
      tick(3);
      cfg_op(1'b0, CCR_FUNC_LINK, CCR_OFF_LINK_FAIL, 32'h0, 32'h10);
      warm_rst_n = 1'b0;
      tick(3);
      leaf_req = 1'b1;
      tick(1);
      leaf_req = 1'b0;
      check({31'h0, leaf_ack}, 32'h0);
      check({28'h0, link_freq_sel}, 32'h0);
      tick(2);
      warm_rst_n = 1'b1;
      tick(2);
      cfg_op(1'b0, CCR_FUNC_LINK, CCR_OFF_LINK_CONN, 32'h0, 32'h10);
      tick(10);
      cfg_op(1'b0, CCR_FUNC_LINK, CCR_OFF_LINK_CONN, 32'h0, 32'h01);
      cfg_op(1'b0, CCR_FUNC_LINK, CCR_OFF_LINK_FAIL, 32'h0, 32'h10);
      cfg_op(1'b1, CCR_FUNC_LINK, CCR_OFF_LINK_FAIL, 32'h10, 32'h0);
      cfg_op(1'b0, CCR_FUNC_LINK, CCR_OFF_LINK_FAIL, 32'h0, 32'h0);
      $display("test warm reset done");
      rst_n = 1'b0;
      link_present = 1'b0;
      tick(2);
      rst_n = 1'b1;
      cfg_op(1'b0, CCR_FUNC_LINK, CCR_OFF_LINK_CONN, 32'h0, 32'h10);
      tick(8);
      cfg_op(1'b0, CCR_FUNC_LINK, CCR_OFF_LINK_CONN, 32'h0, 32'h0);
      cfg_op(1'b0, CCR_FUNC_LINK, CCR_OFF_LINK_FREQ, 32'h0, {CAP, 16'h0});
      $display("test cold reset done");
      give_verdict();
   end
endmodule
